// ---- rtl/host_bus_pkg.sv ----
// shared constants and types of the host access port
// assumes the port runs on the reference clock and that the
// register file behind it answers a read in one clock
package host_bus_pkg;

    // reference clock period and timing figures in reference periods
    localparam int CLK_PERIOD_NS    = 10;
    localparam int WAIT_MAX_TCLK    = 4;
    localparam int SEL_GAP_TCLK     = 4;
    localparam int RESET_HOLD_TCLK  = 8;
    // cycle counts derived from the figures (port clock is the reference)
    localparam int WAIT_CYC         = (WAIT_MAX_TCLK * CLK_PERIOD_NS) / CLK_PERIOD_NS;
    localparam int SEL_GAP_CYC      = (SEL_GAP_TCLK * CLK_PERIOD_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
    // cycles after reset release before straps are trusted
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // data bus width and reset values
    localparam int          DATA_W     = 16;
    localparam logic [15:0] DATA_RESET = 16'h0000;

    // bus style selected at reset
    typedef enum logic [2:0] {
        MODE_ACK    = 3'h0,
        MODE_STB_A  = 3'h1,
        MODE_STB_B  = 3'h2,
        MODE_BYTE   = 3'h3,
        MODE_SERIAL = 3'h4
    } bus_mode_t;

    // parallel access sequence
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_HOLD = 2'h2
    } acc_state_t;

endpackage : host_bus_pkg

// ---- rtl/host_bus_interface_select.sv ----
// host access port: bus style select, strobe buses with wait request,
// acknowledge bus and serial link, all in front of a register file
// assumes every pin is asynchronous to clk_i and the register file
// returns read data in the same clock that reg_rd_o is high
//
// Notes on behaviour
// RULE_01 - straps high/low select the 16-bit style with separate read and write strobes.
// RULE_02 - both straps high select the 8-bit strobe style with byte-wide accesses.
// RULE_03 - read and write strobes both low at reset select the serial link.
// RULE_04 - in strobe styles wait request goes low on the falling edge of chip select.
// RULE_05 - wait request stays low at most four reference periods, then goes high.
// RULE_06 - read data is driven right after wait request is released.
// RULE_07 - after a wait the host counts its write strobe width from wait release.
// RULE_08 - the serial clock runs no faster than the reference clock over 1.5.
// RULE_09 - the select line stays high at least four reference periods between frames.
// RULE_10 - both straps low select the 16-bit style with direction, strobe and acknowledge.
// RULE_11 - straps low/high select a second 16-bit strobe style with wait request.
// RULE_12 - reset is held low for more than eight reference clocks.
`timescale 1ns/1ps

module host_bus_interface_select
    import host_bus_pkg::*;
#(
    parameter int ADDR_W = 5
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    // straps and parallel bus pins
    input  wire logic              bus_style_strap_hi_i,
    input  wire logic              bus_style_strap_lo_i,
    input  wire logic              cs_n_i,
    input  wire logic              rd_n_i,
    input  wire logic              wr_n_i,
    input  wire logic              access_strobe_n_i,
    input  wire logic              rw_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] data_i,
    output logic      [DATA_W-1:0] data_o,
    output logic                   data_oe_b_o,
    output logic                   wait_request_n_o,
    output logic                   ack_n_o,
    // serial link pins
    input  wire logic              sck_i,
    input  wire logic              sel_n_i,
    input  wire logic              sdi_i,
    output logic                   sdo_o,
    output logic                   sdo_oe_b_o,
    // register file side
    output logic                   reg_rd_o,
    output logic                   reg_wr_o,
    output logic      [ADDR_W-1:0] reg_addr_o,
    output logic      [DATA_W-1:0] reg_wdata_o,
    input  wire logic [DATA_W-1:0] reg_rdata_i,
    // selected style
    output bus_mode_t              mode_o,
    output logic                   mode_valid_o
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    localparam int PIN_W  = 10 + ADDR_W + DATA_W;
    localparam int FRAME  = 1 + ADDR_W + DATA_W;
    localparam int CNT_W  = $clog2(FRAME + 1);

    logic [PIN_W-1:0] meta_q;
    logic [PIN_W-1:0] sync_q;
    logic [PIN_W-1:0] pins_w;

    assign pins_w    = {cs_n_i, rd_n_i, wr_n_i, access_strobe_n_i, rw_i, bus_style_strap_hi_i,
                        bus_style_strap_lo_i, sck_i, sel_n_i, sdi_i, addr_i, data_i};

    // two flops on every pin
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= {4'hF, 4'h0, 1'b1, {(PIN_W - 9){1'b0}}}; // strobes and select idle high
            sync_q <= {4'hF, 4'h0, 1'b1, {(PIN_W - 9){1'b0}}};
        end else begin
            meta_q <= pins_w;
            sync_q <= meta_q;
        end
    end

    logic              cs_s, rd_s, wr_s, stb_s, rw_s, hi_s, lo_s, sck_s, sel_s, sdi_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] data_s;
    assign {cs_s, rd_s, wr_s, stb_s, rw_s, hi_s, lo_s, sck_s, sel_s, sdi_s, addr_s, data_s}
        = sync_q;

    // ************************************************************
    // bus style capture after reset release
    // ************************************************************
    logic [1:0] settle_q;
    bus_mode_t  mode_q;
    logic       mode_valid_q;
    bus_mode_t  strap_mode_w;

    assign strap_mode_w = (!rd_s && !wr_s)   ? MODE_SERIAL :   // see RULE_03
                          ( hi_s &&  lo_s)   ? MODE_BYTE   :   // see RULE_02
                          ( hi_s && !lo_s)   ? MODE_STB_B  :   // see RULE_01
                          (!hi_s &&  lo_s)   ? MODE_STB_A  :   // see RULE_11
                                               MODE_ACK;       // see RULE_10

    // straps are caught once the synchronisers hold real pin levels
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            settle_q     <= 2'h0;
            mode_q       <= MODE_ACK;
            mode_valid_q <= 1'b0;
        end else if (!mode_valid_q) begin
            settle_q     <= settle_q + 2'h1;
            mode_valid_q <= (settle_q == STRAP_SETTLE);
            mode_q       <= strap_mode_w;
        end
    end

    // ************************************************************
    // edge detection and decode
    // ************************************************************
    logic cs_d1_q, wr_d1_q, stb_d1_q, sck_d1_q, sel_d1_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            {cs_d1_q, wr_d1_q, stb_d1_q, sck_d1_q, sel_d1_q} <= 5'h1D; // idle pin levels
        end else begin
            {cs_d1_q, wr_d1_q, stb_d1_q, sck_d1_q, sel_d1_q} <= {cs_s, wr_s, stb_s, sck_s, sel_s};
        end
    end

    logic strobe_mode_w, ack_mode_w, ser_mode_w;
    logic cs_fall_w, wr_rise_w, stb_fall_w, stb_rise_w, sck_rise_w, sck_fall_w, sel_rise_w;
    logic start_w, reading_w, release_w;

    assign strobe_mode_w = mode_valid_q && (mode_q != MODE_ACK) && (mode_q != MODE_SERIAL);
    assign ack_mode_w    = mode_valid_q && (mode_q == MODE_ACK);
    assign ser_mode_w    = mode_valid_q && (mode_q == MODE_SERIAL);
    assign cs_fall_w     = cs_d1_q && !cs_s;
    assign wr_rise_w     = !wr_d1_q && wr_s;
    assign stb_fall_w    = stb_d1_q && !stb_s && !cs_s;
    assign stb_rise_w    = !stb_d1_q && stb_s;
    assign sck_rise_w    = !sck_d1_q && sck_s;
    assign sck_fall_w    = sck_d1_q && !sck_s;
    assign sel_rise_w    = !sel_d1_q && sel_s;
    assign start_w       = (strobe_mode_w && cs_fall_w) || (ack_mode_w && stb_fall_w);
    assign reading_w     = ack_mode_w ? rw_s : !rd_s;

    // ************************************************************
    // parallel access sequence
    // ************************************************************
    acc_state_t state_q;
    logic [2:0] wait_cnt_q;
    logic       rd_issued_q;

    // wait request is released on the last of its four cycles
    assign release_w = (state_q == ST_WAIT) && (wait_cnt_q == 3'(WAIT_CYC - 1)); // see RULE_05

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q     <= ST_IDLE;
            wait_cnt_q  <= 3'h0;
            rd_issued_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    wait_cnt_q  <= 3'h0;
                    rd_issued_q <= 1'b0;
                    if (start_w) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    wait_cnt_q  <= wait_cnt_q + 3'h1;
                    rd_issued_q <= rd_issued_q || reading_w;
                    if (release_w) begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if ((ack_mode_w && stb_rise_w) || (!ack_mode_w && cs_s)) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // wait request and acknowledge
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_request_n_o <= 1'b1;
            ack_n_o          <= 1'b1;
        end else begin
            wait_request_n_o <= !(strobe_mode_w && ((state_q == ST_IDLE && start_w)
                                || (state_q == ST_WAIT && !release_w))); // see RULE_04
            ack_n_o          <= !(ack_mode_w && (release_w
                                || (state_q == ST_HOLD && !stb_rise_w))); // see RULE_10
        end
    end

    // ************************************************************
    // serial link
    // ************************************************************
    logic [CNT_W-1:0]  bit_cnt_q;
    logic [FRAME-1:0]  shift_q;
    logic [DATA_W-1:0] sout_q;
    logic [SEL_GAP_CYC-1:0] gap_q;
    logic              ser_rd_w, ser_wr_w, ser_load_q, gap_ok_q;

    // the read request goes out once direction and address are in
    assign ser_rd_w = ser_mode_w && !sel_s && sck_rise_w && (bit_cnt_q == CNT_W'(ADDR_W))
                      && shift_q[ADDR_W-1];
    // a write completes on the select rise after a whole frame
    assign ser_wr_w = ser_mode_w && sel_rise_w && (bit_cnt_q == CNT_W'(FRAME))
                      && !shift_q[FRAME-1];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_cnt_q  <= '0;
            shift_q    <= '0;
            sout_q     <= DATA_RESET;
            ser_load_q <= 1'b0;
            gap_q      <= '0;
            gap_ok_q   <= 1'b0;
            sdo_o      <= 1'b0;
            sdo_oe_b_o <= 1'b1;
        end else begin
            ser_load_q <= ser_rd_w;
            gap_q      <= {gap_q[SEL_GAP_CYC-2:0], sel_s};
            sdo_oe_b_o <= !(ser_mode_w && !sel_s);
            // a frame counts only if select stayed high for the whole gap before it
            if (sel_s) begin // see RULE_09
                bit_cnt_q <= '0;
                gap_ok_q  <= &gap_q;
            end else if (gap_ok_q && sck_rise_w && bit_cnt_q != CNT_W'(FRAME)) begin // see RULE_08
                shift_q   <= {shift_q[FRAME-2:0], sdi_s};
                bit_cnt_q <= bit_cnt_q + CNT_W'(1);
            end
            if (ser_load_q) begin
                sout_q <= reg_rdata_i;
            end else if (sck_fall_w && !sel_s && bit_cnt_q > CNT_W'(ADDR_W + 1)) begin
                sout_q <= {sout_q[DATA_W-2:0], 1'b0};
            end
            sdo_o <= sout_q[DATA_W-1];
        end
    end

    // ************************************************************
    // register file requests and parallel data drive
    // ************************************************************
    logic par_rd_w, par_wr_w, rd_load_q;
    logic [DATA_W-1:0] wdata_w;

    assign par_rd_w = (state_q == ST_WAIT) && !rd_issued_q && reading_w;
    // in strobe styles the write is taken at the strobe rise, after wait release
    assign par_wr_w = (state_q == ST_HOLD) && (ack_mode_w ? (stb_rise_w && !rw_s)
                                                          : wr_rise_w); // see RULE_07
    assign wdata_w  = (mode_q == MODE_BYTE) ? {8'h00, data_s[7:0]} : data_s; // see RULE_02

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rd_o    <= 1'b0;
            reg_wr_o    <= 1'b0;
            reg_addr_o  <= '0;
            reg_wdata_o <= DATA_RESET;
            rd_load_q   <= 1'b0;
            data_o      <= DATA_RESET;
            data_oe_b_o <= 1'b1;
        end else begin
            reg_rd_o  <= par_rd_w || ser_rd_w;
            reg_wr_o  <= par_wr_w || ser_wr_w;
            rd_load_q <= par_rd_w;
            // a serial read goes out with the last address bit still on the input
            if (ser_wr_w) begin
                reg_addr_o <= shift_q[FRAME-2 -: ADDR_W];
            end else if (ser_rd_w) begin
                reg_addr_o <= {shift_q[ADDR_W-2:0], sdi_s};
            end else if (par_rd_w || par_wr_w) begin
                reg_addr_o <= addr_s;
            end
            if (ser_wr_w) begin
                reg_wdata_o <= shift_q[DATA_W-1:0];
            end else if (par_wr_w) begin
                reg_wdata_o <= wdata_w;
            end
            if (rd_load_q) begin
                data_o <= (mode_q == MODE_BYTE) ? {8'h00, reg_rdata_i[7:0]} : reg_rdata_i;
            end
            // data leaves the bus with the read strobe, appears at wait release
            data_oe_b_o <= !(reading_w && (release_w
                           || (state_q == ST_HOLD && !cs_s && !stb_rise_w))); // see RULE_06
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    wait_length_a: assert property ($fell(wait_request_n_o) |->  // see RULE_05
        !wait_request_n_o [*4] ##1 wait_request_n_o)
        else $error("wait request not held for exactly four clocks");
    wait_on_cs_a: assert property (strobe_mode_w && state_q == ST_IDLE && cs_fall_w  // see RULE_04
        |=> !wait_request_n_o)
        else $error("wait request missed chip select fall");
    read_drive_a: assert property ($rose(wait_request_n_o) && rd_issued_q && !rd_s  // see RULE_06
        |-> !data_oe_b_o)
        else $error("read data not driven at wait release");
    strap_byte_a: assert property ($rose(mode_valid_q) && $past(hi_s && lo_s && (rd_s || wr_s))  // see RULE_02
        |-> mode_q == MODE_BYTE)
        else $error("byte style not chosen");
    strap_stb_a: assert property ($rose(mode_valid_q) && $past(hi_s != lo_s && (rd_s || wr_s))  // see RULE_01
        |-> mode_q == ($past(hi_s) ? MODE_STB_B : MODE_STB_A))
        else $error("strobe style not chosen");
    strap_serial_a: assert property ($rose(mode_valid_q) && $past(!rd_s && !wr_s)  // see RULE_03
        |-> mode_q == MODE_SERIAL ##1 wait_request_n_o && data_oe_b_o)
        else $error("serial style not chosen");
    ack_no_wait_a: assert property (ack_mode_w |-> wait_request_n_o  // see RULE_10
        and ($fell(ack_n_o) |-> $past(state_q == ST_WAIT)))
        else $error("acknowledge style timing broken");
    write_once_a: assert property (par_wr_w |=> reg_wr_o ##1 !reg_wr_o)  // see RULE_07
        else $error("parallel write not issued as one pulse");
    mode_hold_a: assert property (mode_valid_q |=> $stable(mode_q) && mode_valid_q)  // see RULE_11
        else $error("bus style changed after capture");

    read_seen_c:  cover property ($rose(wait_request_n_o) ##1 !data_oe_b_o);
    write_seen_c: cover property (par_wr_w);
    ser_read_c:   cover property (ser_rd_w ##[1:200] sel_rise_w);

    assign mode_o       = mode_q;
    assign mode_valid_o = mode_valid_q;

endmodule : host_bus_interface_select

// ---- verif/host_model.sv ----
// host side partner: bus master for the strobe, acknowledge and serial styles
// assumes a 5-bit address and a port that samples every pin on the rising clock
`timescale 1ns/1ps

module host_model (
    // clock and device answers
    input  wire logic        clk_i,
    input  wire logic        wait_n_i,
    input  wire logic        ack_n_i,
    input  wire logic [15:0] rdata_i,
    input  wire logic        oe_b_i,
    input  wire logic        sdo_i,
    // host pins
    output logic             cs_n_o,
    output logic             rd_n_o,
    output logic             wr_n_o,
    output logic             access_strobe_n_o,
    output logic             rw_o,
    output logic [4:0]       addr_o,
    output logic [15:0]      wdata_o,
    output logic             sck_o,
    output logic             sel_n_o,
    output logic             sdi_o,
    output logic             hung_o
);
    localparam int HALF = 5;
    localparam int GAP  = 6;

    // ************************************************************
    // idle levels: pulled-up controls high, floating lines inverted
    // ************************************************************
    initial begin
        {cs_n_o, rd_n_o, wr_n_o, access_strobe_n_o, rw_o, sel_n_o, sdi_o} = 7'h7F;
        addr_o = 5'h0A;
        wdata_o = 16'h5A5A;
        sck_o = 1'b0;
        hung_o = 1'b0;
    end

    // strobes held low in reset pick the serial link
    task automatic set_idle(input logic ser);
        rd_n_o = ~ser;
        wr_n_o = ~ser;
    endtask : set_idle

    // strobe access: hold everything until the wait request is seen released
    task automatic strobe_acc(input logic rd, input logic [4:0] a, input logic [15:0] d,
                              output int dly, output int wcnt, output logic [15:0] q,
                              output logic oe_b);
        @(negedge clk_i);
        cs_n_o = 1'b0;
        rd_n_o = ~rd;
        wr_n_o = rd;
        addr_o = a;
        wdata_o = rd ? ~wdata_o : d;
        dly = 0;
        wcnt = 0;
        while (wait_n_i !== 1'b0 && dly < 12) begin
            @(negedge clk_i);
            dly++;
        end
        while (wait_n_i === 1'b0 && wcnt < 12) begin
            @(negedge clk_i);
            wcnt++;
        end
        if (dly >= 12 || wcnt >= 12) hung_o = 1'b1;
        q = rdata_i;
        oe_b = oe_b_i;
        repeat (3) @(negedge clk_i);  // strobe width counted from wait release
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        @(negedge clk_i);
        cs_n_o = 1'b1;
        addr_o = ~a;
        wdata_o = ~wdata_o;
        repeat (6) @(negedge clk_i);
    endtask : strobe_acc

    // acknowledge access: strobe stays low until the acknowledge is seen
    task automatic ack_acc(input logic rd, input logic [4:0] a, input logic [15:0] d,
                           output logic [15:0] q);
        int n;
        @(negedge clk_i);
        cs_n_o = 1'b0;
        rw_o = rd;
        addr_o = a;
        wdata_o = d;
        access_strobe_n_o = 1'b0;
        n = 0;
        while (ack_n_i !== 1'b0 && n < 16) begin
            @(negedge clk_i);
            n++;
        end
        q = rdata_i;
        access_strobe_n_o = 1'b1;
        while (ack_n_i !== 1'b1 && n < 32) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 16) hung_o = 1'b1;
        cs_n_o = 1'b1;
        addr_o = ~a;
        wdata_o = ~d;
        repeat (6) @(negedge clk_i);
    endtask : ack_acc

    // serial frame: direction, address msb first, then 16 data bits
    task automatic ser_frame(input logic rd, input logic [4:0] a, input logic [15:0] d,
                             output logic [15:0] q);
        logic [21:0] bits;
        bits = {rd, a, d};
        q = 16'h0000;
        @(negedge clk_i);
        sel_n_o = 1'b0;
        repeat (2) @(negedge clk_i);
        for (int i = 21; i >= 0; i--) begin
            sck_o = 1'b0;
            sdi_o = bits[i];
            repeat (HALF) @(negedge clk_i);  // slow serial clock
            if (i < 16) q[i] = sdo_i;
            sck_o = 1'b1;
            repeat (HALF) @(negedge clk_i);
        end
        sck_o = 1'b0;
        sdi_o = 1'b1;
        @(negedge clk_i);
        sel_n_o = 1'b1;
        repeat (GAP) @(negedge clk_i);  // select high between frames
    endtask : ser_frame

endmodule : host_model

// ---- verif/tb.sv ----
// testbench: resets the port in every bus style and runs accesses through the host model
// assumes the register file answers a read with a pattern built from the address
`timescale 1ns/1ps

module tb;
    import host_bus_pkg::*;

    // ************************************************************
    // signals
    // ************************************************************
    logic        clk, rst_b, strap_hi, strap_lo;
    logic        cs_n, rd_n, wr_n, stb_n, rw, sck, sel_n, sdi, sdo, sdo_oe_b;
    logic        oe_b, wait_n, ack_n, reg_rd, reg_wr, mode_valid, hung;
    logic [4:0]  addr, reg_addr, wr_addr;
    logic [15:0] hdata, ddata, reg_wdata, reg_rdata, wr_data;
    bus_mode_t   mode;
    int          n_fail = 0;
    int          checks = 0;
    int          wr_cnt = 0;
    int          rd_cnt = 0;

    initial clk = 1'b0;
    always #5 clk = ~clk;

    // register file: read pattern and write log
    assign reg_rdata = {8'hC3, reg_addr, 3'h5};
    always @(posedge clk) begin
        if (reg_rd === 1'b1) begin
            rd_cnt <= rd_cnt + 1;
        end
        if (reg_wr === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            wr_addr <= reg_addr;
            wr_data <= reg_wdata;
        end
    end

    host_bus_interface_select #(.ADDR_W(5)) u_host_bus_interface_select (
        .clk_i(clk), .rst_b_i(rst_b), .bus_style_strap_hi_i(strap_hi),
        .bus_style_strap_lo_i(strap_lo), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .access_strobe_n_i(stb_n), .rw_i(rw), .addr_i(addr), .data_i(hdata),
        .data_o(ddata), .data_oe_b_o(oe_b), .wait_request_n_o(wait_n), .ack_n_o(ack_n),
        .sck_i(sck), .sel_n_i(sel_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_b_o(sdo_oe_b),
        .reg_rd_o(reg_rd), .reg_wr_o(reg_wr), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata), .mode_o(mode),
        .mode_valid_o(mode_valid));

    // an undriven data line shows the inverse of the last value
    host_model u_host_model (
        .clk_i(clk), .wait_n_i(wait_n), .ack_n_i(ack_n), .rdata_i(oe_b ? ~ddata : ddata),
        .oe_b_i(oe_b), .sdo_i(sdo_oe_b ? ~sdo : sdo), .cs_n_o(cs_n), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .access_strobe_n_o(stb_n),
        .rw_o(rw), .addr_o(addr), .wdata_o(hdata), .sck_o(sck), .sel_n_o(sel_n),
        .sdi_o(sdi), .hung_o(hung));

    // ************************************************************
    // checking and closing
    // ************************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    task automatic hang_chk();
        if (hung !== 1'b0) begin
            n_fail++;
            $display("ERROR at %0t: host wait ran out", $time);
            wrap_up();
        end
    endtask : hang_chk

    task automatic do_reset(input logic hi, input logic lo, input logic ser);
        @(negedge clk);
        rst_b = 1'b0;
        strap_hi = hi;
        strap_lo = lo;
        u_host_model.set_idle(ser);
        repeat (10) @(negedge clk);  // reset held over eight clocks
        rst_b = 1'b1;
        repeat (6) @(negedge clk);
    endtask : do_reset

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic test_modes();
        bus_mode_t want[5];
        want = '{MODE_ACK, MODE_STB_A, MODE_STB_B, MODE_BYTE, MODE_SERIAL};
        for (int m = 0; m < 5; m++) begin
            do_reset(m[1], m[0], m == 4);
            chk(16'(mode), 16'(want[m]), "mode");
            chk({15'h0, mode_valid}, 16'h0001, "mode valid");
        end
        $display("style select test done");
    endtask : test_modes

    task automatic test_strobe(input logic hi, input logic lo);
        int          dly, wcnt, n0;
        logic [15:0] q, mask;
        logic        ob;
        mask = (hi & lo) ? 16'h00FF : 16'hFFFF;
        do_reset(hi, lo, 1'b0);
        n0 = rd_cnt;
        u_host_model.strobe_acc(1'b1, 5'h1F, 16'h0000, dly, wcnt, q, ob);
        hang_chk();
        chk(16'(dly <= 5), 16'h0001, "wait onset");
        chk(16'(wcnt), 16'h0004, "wait length");
        chk(q, {8'hC3, 5'h1F, 3'h5} & mask, "read data");
        chk({15'h0, ob}, 16'h0000, "data drive");
        chk({15'h0, oe_b}, 16'h0001, "bus released");
        chk(16'(rd_cnt - n0), 16'h0001, "read count");
        n0 = wr_cnt;
        u_host_model.strobe_acc(1'b0, 5'h0B, 16'hBEEF, dly, wcnt, q, ob);
        hang_chk();
        chk(16'(wcnt), 16'h0004, "write wait");
        chk(16'(wr_cnt - n0), 16'h0001, "write count");
        chk(16'(wr_addr), 16'h000B, "write addr");
        chk(wr_data, 16'hBEEF & mask, "write data");
        $display("strobe test straps %b%b done", hi, lo);
    endtask : test_strobe

    task automatic test_ack();
        logic [15:0] q;
        int          n0;
        do_reset(1'b0, 1'b0, 1'b0);
        u_host_model.ack_acc(1'b1, 5'h05, 16'h0000, q);
        hang_chk();
        chk(q, {8'hC3, 5'h05, 3'h5}, "ack read");
        n0 = wr_cnt;
        u_host_model.ack_acc(1'b0, 5'h12, 16'h1234, q);
        hang_chk();
        chk(16'(wr_cnt - n0), 16'h0001, "ack writes");
        chk(16'(wr_addr), 16'h0012, "ack waddr");
        chk(wr_data, 16'h1234, "ack wdata");
        $display("acknowledge test done");
    endtask : test_ack

    task automatic test_serial();
        logic [15:0] q;
        int          n0;
        do_reset(1'b0, 1'b0, 1'b1);
        n0 = wr_cnt;
        u_host_model.ser_frame(1'b0, 5'h15, 16'hC0DE, q);
        chk(16'(wr_cnt - n0), 16'h0001, "ser writes");
        chk(16'(wr_addr), 16'h0015, "ser waddr");
        chk(wr_data, 16'hC0DE, "ser wdata");
        u_host_model.ser_frame(1'b1, 5'h0A, 16'h0000, q);
        chk(q, {8'hC3, 5'h0A, 3'h5}, "ser read");
        chk({15'h0, sdo_oe_b}, 16'h0001, "ser released");
        $display("serial test done");
    endtask : test_serial

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        rst_b = 1'b0;
        strap_hi = 1'b0;
        strap_lo = 1'b0;
        test_modes();
        test_strobe(1'b1, 1'b0);
        test_strobe(1'b0, 1'b1);
        test_strobe(1'b1, 1'b1);
        test_ack();
        test_serial();
        wrap_up();
    end

    initial begin
        #200us;
        n_fail++;
        $display("ERROR at %0t: run timed out", $time);
        wrap_up();
    end

endmodule : tb
